// >>> rtl/ccr_pkg.sv
// Constants for the management port, clocking and reset block
`default_nettype none
package ccr_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   // Management port register indices (word offsets on the 16-bit address)
   localparam logic [15:0] SCRATCH_OFS   = 16'h0000;
   localparam logic [15:0] CTRL_OFS      = 16'h0001;
   localparam logic [15:0] RST_CTRL_OFS  = 16'h0002;
   localparam logic [15:0] STATUS_OFS    = 16'h0003;
   localparam logic [15:0] ID_OFS        = 16'h0004;
   // Arbitrary identification value
   localparam logic [31:0] ID_VALUE      = 32'h0000_c5a1;
   localparam logic [31:0] SCRATCH_RST   = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   localparam logic [31:0] READDATA_RST  = 32'h0000_0000;
   // Control register fields
   localparam int CTRL_RATE_LSB  = 0;
   localparam int CTRL_SYNCE_BIT = 2;
   localparam logic [1:0] RATE_STANDARD = 2'h0;
   localparam logic [1:0] RATE_CAUI4    = 2'h1;
   localparam logic [1:0] RATE_REDUCED  = 2'h2;
   localparam logic [2:0] CTRL_RST      = 3'h0;
   // Soft reset bit positions, same order as the async inputs
   localparam int RST_MAC_RX  = 0;
   localparam int RST_MAC_TX  = 1;
   localparam int RST_COD_RX  = 2;
   localparam int RST_COD_TX  = 3;
   localparam int RST_SERDES  = 4;
   localparam int NUM_RST     = 5;
   localparam logic [4:0] RST_CTRL_RST = 5'h00;
   localparam logic [4:0] STATUS_RST   = 5'h00;
   // PCS clock frequencies in kHz per configuration
   localparam int PCS_KHZ_STANDARD = 257813;
   localparam int PCS_KHZ_CAUI4    = 201416;
   localparam int PCS_KHZ_REDUCED  = 156250;
   // Minimum client clock frequencies in kHz
   localparam int MAC_MIN_KHZ_STANDARD = 315000;
   localparam int MAC_MIN_KHZ_REDUCED  = 190900;
   localparam int SYNC_STAGES = 2;
   localparam int RD_LATENCY  = 1;
endpackage
`default_nettype wire

// >>> rtl/ccr_rst_sync.sv
// Reset synchroniser: asynchronous assert, synchronised release
`timescale 1ns/1ps
`default_nettype none
module ccr_rst_sync #(
   parameter int STAGES = 2
) (
   input  wire logic clk,
   input  wire logic arst,
   output logic      srst
);
   logic [STAGES-1:0] chain_q;

   // Release walks through the chain so the domain leaves reset cleanly
   always_ff @(posedge clk or posedge arst)
   begin
      if (arst)
      begin
         chain_q <= '1;
      end
      else
      begin
         chain_q <= {chain_q[STAGES-2:0], 1'b0};
      end
   end

   assign srst = chain_q[STAGES-1];
endmodule
`default_nettype wire

// >>> rtl/ccr_top.sv
// Management port, clock selection and reset distribution of the MAC/PHY core
//
// Overview of operation
// - Port takes 16-bit address, read and write strobes, 32-bit write data.
// - Each read returns 32-bit data with a valid pulse marking it.
// - Port is sampled and driven on the slow housekeeping clock.
// - Sync-E mode uses separate TX and RX references, exports recovered clock.
// - PCS clock frequency follows standard, CAUI-4 or reduced rate setting.
// - Resets come from async inputs and from writable register bits.
// - Five async reset inputs, each resetting only its own part.
`timescale 1ns/1ps
`default_nettype none
module ccr_top #(
   parameter int STAGES = ccr_pkg::SYNC_STAGES
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [15:0] mgmt_addr,
   input  wire logic        mgmt_read,
   input  wire logic        mgmt_write,
   input  wire logic [31:0] mgmt_writedata,
   output logic      [31:0] mgmt_readdata,
   output logic             mgmt_readdata_valid,
   input  wire logic        ref_clk,
   input  wire logic        tx_ref_clk,
   input  wire logic        rx_ref_clk,
   input  wire logic        rx_recovered_clk_in,
   output logic             txpll_ref_clk,
   output logic             cdr_ref_clk,
   output logic             rx_recovered_clk,
   output logic      [1:0]  pcs_rate_sel,
   output logic             synce_en,
   input  wire logic        clk_txmac,
   input  wire logic        clk_rxmac,
   input  wire logic        clk_pcs_tx,
   input  wire logic        clk_pcs_rx,
   input  wire logic        mac_rx_async_rst,
   input  wire logic        mac_tx_async_rst,
   input  wire logic        coding_rx_async_rst,
   input  wire logic        coding_tx_async_rst,
   input  wire logic        serdes_async_rst,
   output logic             mac_rx_rst,
   output logic             mac_tx_rst,
   output logic             coding_rx_rst,
   output logic             coding_tx_rst,
   output logic             serdes_rst
);
   logic [31:0]                  scratch_q;
   logic [2:0]                   ctrl_q;
   logic [ccr_pkg::NUM_RST-1:0]  soft_rst_q;
   logic [31:0]                  rdata_d;
   logic [ccr_pkg::NUM_RST-1:0]  domain_rst;
   logic [ccr_pkg::NUM_RST-1:0]  comb_rst;
   logic [ccr_pkg::NUM_RST-1:0]  async_in;
   logic [ccr_pkg::NUM_RST-1:0]  dom_clk;
   logic [ccr_pkg::NUM_RST-1:0]  status_meta_q;
   logic [ccr_pkg::NUM_RST-1:0]  status_q;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction

   // Sync-E picks the dedicated reference, otherwise the shared one
   function automatic logic steer(input logic sel, input logic dedicated, input logic shared);
      steer = sel ? dedicated : shared;
   endfunction

   // Register writes on the housekeeping clock, one process per register
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         scratch_q <= ccr_pkg::SCRATCH_RST;
      end
      else if (mgmt_write && hit(mgmt_addr, ccr_pkg::SCRATCH_OFS))
      begin
         scratch_q <= mgmt_writedata;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         ctrl_q <= ccr_pkg::CTRL_RST;
      end
      else if (mgmt_write && hit(mgmt_addr, ccr_pkg::CTRL_OFS))
      begin
         ctrl_q <= mgmt_writedata[2:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         soft_rst_q <= ccr_pkg::RST_CTRL_RST;
      end
      else if (mgmt_write && hit(mgmt_addr, ccr_pkg::RST_CTRL_OFS))
      begin
         soft_rst_q <= mgmt_writedata[ccr_pkg::NUM_RST-1:0];
      end
   end

   // Status shows each part's reset as seen after release synchronisation
   always_comb
   begin
      rdata_d = ccr_pkg::UNMAPPED_DATA;
      case (mgmt_addr)
         ccr_pkg::SCRATCH_OFS:  rdata_d = scratch_q;
         ccr_pkg::CTRL_OFS:     rdata_d = {29'h0, ctrl_q};
         ccr_pkg::RST_CTRL_OFS: rdata_d = {27'h0, soft_rst_q};
         ccr_pkg::STATUS_OFS:   rdata_d = {27'h0, status_q};
         ccr_pkg::ID_OFS:       rdata_d = ccr_pkg::ID_VALUE;
         default:               rdata_d = ccr_pkg::UNMAPPED_DATA;
      endcase
   end

   // Valid pulses once per read command
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         mgmt_readdata_valid <= 1'b0;
      end
      else
      begin
         mgmt_readdata_valid <= mgmt_read;
      end
   end

   // One-cycle read latency; a write in the same cycle is not reflected
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         mgmt_readdata <= ccr_pkg::READDATA_RST;
      end
      else if (mgmt_read)
      begin
         mgmt_readdata <= rdata_d;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         pcs_rate_sel <= ccr_pkg::RATE_STANDARD;
      end
      else
      begin
         pcs_rate_sel <= ctrl_q[ccr_pkg::CTRL_RATE_LSB +: 2];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         synce_en <= 1'b0;
      end
      else
      begin
         synce_en <= ctrl_q[ccr_pkg::CTRL_SYNCE_BIT];
      end
   end

   // Clock steering is glitch-prone if switched live; change only under reset
   assign txpll_ref_clk    = steer(synce_en, tx_ref_clk, ref_clk);
   assign cdr_ref_clk      = steer(synce_en, rx_ref_clk, ref_clk);
   assign rx_recovered_clk = synce_en & rx_recovered_clk_in;

   // Named positions keep each input tied to its own domain clock
   assign async_in[ccr_pkg::RST_MAC_RX] = mac_rx_async_rst;
   assign async_in[ccr_pkg::RST_MAC_TX] = mac_tx_async_rst;
   assign async_in[ccr_pkg::RST_COD_RX] = coding_rx_async_rst;
   assign async_in[ccr_pkg::RST_COD_TX] = coding_tx_async_rst;
   assign async_in[ccr_pkg::RST_SERDES] = serdes_async_rst;
   assign dom_clk[ccr_pkg::RST_MAC_RX]  = clk_rxmac;
   assign dom_clk[ccr_pkg::RST_MAC_TX]  = clk_txmac;
   assign dom_clk[ccr_pkg::RST_COD_RX]  = clk_pcs_rx;
   assign dom_clk[ccr_pkg::RST_COD_TX]  = clk_pcs_tx;
   assign dom_clk[ccr_pkg::RST_SERDES]  = clock;
   // Soft bits are registered so they are glitch free into the async path
   assign comb_rst = async_in | soft_rst_q;

   for (genvar i = 0; i < ccr_pkg::NUM_RST; i++)
   begin : g_rst
      ccr_rst_sync #(
         .STAGES (STAGES)
      ) u_sync (
         .clk  (dom_clk[i]),
         .arst (comb_rst[i]),
         .srst (domain_rst[i])
      );
   end

   // Client domains run on other clocks; two flops before status reads them
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         status_meta_q <= ccr_pkg::STATUS_RST;
         status_q      <= ccr_pkg::STATUS_RST;
      end
      else
      begin
         status_meta_q <= domain_rst;
         status_q      <= status_meta_q;
      end
   end

   assign mac_rx_rst    = domain_rst[ccr_pkg::RST_MAC_RX];
   assign mac_tx_rst    = domain_rst[ccr_pkg::RST_MAC_TX];
   assign coding_rx_rst = domain_rst[ccr_pkg::RST_COD_RX];
   assign coding_tx_rst = domain_rst[ccr_pkg::RST_COD_TX];
   assign serdes_rst    = domain_rst[ccr_pkg::RST_SERDES];
endmodule
`default_nettype wire

// >>> verification/ccr_assertions.sv
// Checker for the management port and reset outputs
`timescale 1ns/1ps
`default_nettype none
module ccr_assertions (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic [15:0] mgmt_addr,
   input wire logic        mgmt_read,
   input wire logic        mgmt_write,
   input wire logic [31:0] mgmt_writedata,
   input wire logic [31:0] mgmt_readdata,
   input wire logic        mgmt_readdata_valid,
   input wire logic        rx_recovered_clk,
   input wire logic [1:0]  pcs_rate_sel,
   input wire logic        synce_en,
   input wire logic        mac_tx_async_rst,
   input wire logic        serdes_async_rst,
   input wire logic        mac_tx_rst,
   input wire logic        serdes_rst
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence ctrl_wr; mgmt_write && mgmt_addr == ccr_pkg::CTRL_OFS; endsequence
   sequence id_rd; mgmt_read && mgmt_addr == ccr_pkg::ID_OFS; endsequence
   chk_read_answer: assert property (mgmt_read |=> mgmt_readdata_valid)
      else $error("read not answered");
   chk_no_spurious: assert property (!mgmt_read |=> !mgmt_readdata_valid)
      else $error("valid without read");
   chk_id_value: assert property (id_rd |=> mgmt_readdata == ccr_pkg::ID_VALUE)
      else $error("wrong identity word");
   chk_data_holds: assert property (!mgmt_read |=> $stable(mgmt_readdata))
      else $error("read data moved");
   chk_rate_write: assert property (ctrl_wr |=> ##1 pcs_rate_sel == $past(mgmt_writedata[1:0], 2))
      else $error("rate select not taken");
   chk_synce_gate: assert property (!synce_en |-> !rx_recovered_clk)
      else $error("recovered clock leaks");
   chk_reset_clear: assert property ($rose(rstn) |-> !synce_en && pcs_rate_sel == 2'h0)
      else $error("control not cleared");
   chk_serdes_async: assert property (serdes_async_rst |-> serdes_rst)
      else $error("serdes reset late");
   chk_mactx_async: assert property (mac_tx_async_rst |-> mac_tx_rst)
      else $error("mac tx reset late");
endmodule
bind ccr_top ccr_assertions ccr_assertions_i (.*);
`default_nettype wire

// >>> verification/ccr_host_model.sv
// Management bus master model
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
   input  wire logic        clock,
   input  wire logic [31:0] mgmt_readdata,
   input  wire logic        mgmt_readdata_valid,
   output logic      [15:0] mgmt_addr,
   output logic             mgmt_read,
   output logic             mgmt_write,
   output logic      [31:0] mgmt_writedata
);
   initial
   begin
      mgmt_addr = 16'h0000;
      mgmt_read = 1'b0;
      mgmt_write = 1'b0;
      mgmt_writedata = 32'h0000_0000;
   end
   // Released lines show the inverse so stale values never match
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge clock);
      mgmt_addr = a;
      mgmt_writedata = d;
      mgmt_write = 1'b1;
      @(negedge clock);
      mgmt_write = 1'b0;
      mgmt_addr = ~a;
      mgmt_writedata = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
      @(negedge clock);
      mgmt_addr = a;
      mgmt_read = 1'b1;
      // Valid stands for one cycle only, so take it before releasing
      @(negedge clock);
      v = mgmt_readdata_valid;
      d = mgmt_readdata;
      mgmt_read = 1'b0;
      mgmt_addr = ~a;
   endtask
endmodule
`default_nettype wire

// >>> verification/tb_csr_port_clock_reset.sv
// Testbench for the management port and reset block
`timescale 1ns/1ps
`default_nettype none
module tb_csr_port_clock_reset;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [4:0] arst = 5'h1f;
   logic mac_clk = 1'b0;
   int errors = 0;
   int num_checks = 0;
   wire [15:0] mgmt_addr;
   wire [31:0] mgmt_writedata, mgmt_readdata;
   wire mgmt_read, mgmt_write, mgmt_readdata_valid, txpll_ref_clk, cdr_ref_clk, rx_recovered_clk, synce_en;
   wire [1:0] pcs_rate_sel;
   // RX reference runs inverted; TX reference is the gated recovered clock, inverted only while synce_en is set
   wire ref_clk = clock, rx_ref_clk = ~clock, rx_recovered_clk_in = ~clock, clk_txmac = mac_clk;
   wire clk_rxmac = mac_clk, clk_pcs_tx = clock, clk_pcs_rx = clock;
   wire tx_ref_clk = rx_recovered_clk;
   wire mac_rx_async_rst = arst[0], mac_tx_async_rst = arst[1], coding_rx_async_rst = arst[2];
   wire coding_tx_async_rst = arst[3], serdes_async_rst = arst[4];
   wire mac_rx_rst, mac_tx_rst, coding_rx_rst, coding_tx_rst, serdes_rst;
   wire [4:0] rst_out = {serdes_rst, coding_tx_rst, coding_rx_rst, mac_tx_rst, mac_rx_rst};
   always #10 clock = ~clock;
   // Client clocks at 333 MHz, above the minimum for every rate
   always #1.5 mac_clk = ~mac_clk;
   ccr_top ccr_top_i (.*);
   ccr_host_model ccr_host_model_i (.*);
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic t_port();
      logic [31:0] d;
      logic v;
      ccr_host_model_i.rd(ccr_pkg::ID_OFS, d, v);
      chk("valid", {31'h0, v}, 32'h1);
      chk("id", d, ccr_pkg::ID_VALUE);
      ccr_host_model_i.wr(ccr_pkg::SCRATCH_OFS, 32'ha5c3_0ff1);
      ccr_host_model_i.rd(ccr_pkg::SCRATCH_OFS, d, v);
      chk("scratch", d, 32'ha5c3_0ff1);
      ccr_host_model_i.rd(16'hfffe, d, v);
      chk("unmapped", d, ccr_pkg::UNMAPPED_DATA);
      // Mid-run reset must clear what software wrote
      @(negedge clock);
      rstn = 1'b0;
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      ccr_host_model_i.rd(ccr_pkg::SCRATCH_OFS, d, v);
      chk("scratch reset", d, ccr_pkg::SCRATCH_RST);
      $display("port test done");
   endtask
   task automatic t_rates();
      for (int r = 0; r < 3; r++)
      begin
         ccr_host_model_i.wr(ccr_pkg::CTRL_OFS, 32'(r));
         // Rate select is registered once more behind the control word
         @(negedge clock);
         #1;
         chk("rate", {30'h0, pcs_rate_sel}, 32'(r));
      end
      chk("shared tx ref", {31'h0, txpll_ref_clk}, 32'h0);
      chk("shared cdr ref", {31'h0, cdr_ref_clk}, 32'h0);
      chk("gated recovered", {31'h0, rx_recovered_clk}, 32'h0);
      @(negedge clock);
      arst = 5'h1f;
      // Mux select only moves under reset to avoid clock glitches
      ccr_host_model_i.wr(ccr_pkg::CTRL_OFS, 32'h4);
      @(negedge clock);
      #1;
      chk("synce", {31'h0, synce_en}, 32'h1);
      chk("recovered", {31'h0, rx_recovered_clk}, 32'h1);
      chk("synce tx ref", {31'h0, txpll_ref_clk}, 32'h1);
      chk("synce cdr ref", {31'h0, cdr_ref_clk}, 32'h1);
      @(negedge clock);
      arst = 5'h0;
      repeat (2) @(negedge clock);
      chk("clock release", {27'h0, rst_out}, 32'h0);
      $display("clock test done");
   endtask
   task automatic t_resets();
      logic [4:0] masks [4] = '{5'h01, 5'h0a, 5'h04, 5'h10};
      logic [31:0] d;
      logic v;
      foreach (masks[i])
      begin
         @(negedge clock);
         arst = masks[i];
         #1;
         chk("assert", {27'h0, rst_out}, {27'h0, masks[i]});
         @(negedge clock);
         arst = 5'h0;
         @(negedge clock);
         // Fast client domains are out already; housekeeping-rate parts still hold
         chk("hold", {27'h0, rst_out}, {27'h0, masks[i] & 5'h1c});
         @(negedge clock);
         chk("release", {27'h0, rst_out}, 32'h0);
      end
      ccr_host_model_i.wr(ccr_pkg::RST_CTRL_OFS, 32'h0000_0010);
      chk("soft assert", {27'h0, rst_out}, 32'h0000_0010);
      // Status passes a two-flop synchroniser before it can be read
      repeat (2) @(negedge clock);
      ccr_host_model_i.rd(ccr_pkg::STATUS_OFS, d, v);
      chk("status", d, 32'h0000_0010);
      ccr_host_model_i.rd(ccr_pkg::RST_CTRL_OFS, d, v);
      chk("soft readback", d, 32'h0000_0010);
      ccr_host_model_i.wr(ccr_pkg::RST_CTRL_OFS, 32'h0000_0000);
      repeat (2) @(negedge clock);
      chk("soft release", {27'h0, rst_out}, 32'h0);
      $display("reset test done");
   endtask
   initial
   begin
      repeat (8) @(negedge clock);
      rstn = 1'b1;
      arst = 5'h0;
      t_port();
      t_rates();
      t_resets();
      end_sim();
   end
   initial
   begin
      #100000;
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
